// *** hdl/sdmc_defs.svh ***
`ifndef SDMC_DEFS_SVH
`define SDMC_DEFS_SVH
// Register indices; the byte address on the bus is four times the index.
`define SDMC_IDX_ADDR 6'h00
`define SDMC_IDX_PAGE 6'h02
`define SDMC_IDX_COUNT 6'h04
`define SDMC_IDX_CMD 6'h08
`define SDMC_IDX_REQ 6'h09
`define SDMC_IDX_MODE 6'h0b
`define SDMC_IDX_CLEAR 6'h0d
`define SDMC_IDX_MASK 6'h0f
`define SDMC_IDX_WIDTH 6'h10
// Mode register field positions.
`define SDMC_MODE_SEL_HI 7
`define SDMC_MODE_SEL_LO 6
`define SDMC_MODE_DIR_BIT 5
`define SDMC_MODE_AUTO_BIT 4
`define SDMC_MODE_KIND_HI 3
`define SDMC_MODE_KIND_LO 2
// Other field positions.
`define SDMC_CMD_DIS_BIT 2
`define SDMC_MASK_BIT 0
`define SDMC_WIDTH_BIT 0
// Reset values.
`define SDMC_MODE_RST 6'h00
`define SDMC_CMD_DIS_RST 1'b0
`define SDMC_MASK_RST 1'b1
`define SDMC_ADDR_RST 16'h0000
`define SDMC_PAGE_RST 8'h00
`define SDMC_COUNT_RST 16'h0000
// Bus answers.
`define SDMC_RESP_OKAY 2'h0
`define SDMC_RESP_SLVERR 2'h2
`endif

// *** hdl/sdmc_pkg.sv ***
package sdmc_pkg;
	// Transfer mode select field.
	typedef enum logic [1:0] {
		SDMC_MODE_DEMAND = 2'h0,
		SDMC_MODE_SINGLE = 2'h1,
		SDMC_MODE_BLOCK = 2'h2,
		SDMC_MODE_UNUSED_BITS = 2'h3
	} sdmc_mode_t;
	// Transfer kind field.
	typedef enum logic [1:0] {
		SDMC_KIND_NONE = 2'h0,
		SDMC_KIND_WRITE = 2'h1,
		SDMC_KIND_READ = 2'h2,
		SDMC_KIND_UNUSED_BITS = 2'h3
	} sdmc_kind_t;
endpackage : sdmc_pkg

// *** hdl/sdmc_xfer.sv ***
`timescale 1ns/1ps
`default_nettype none
module sdmc_xfer
	import sdmc_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic clr_i,
	input wire logic load_addr_i,
	input wire logic load_cnt_i,
	input wire logic [23:0] base_addr_i,
	input wire logic [15:0] base_cnt_i,
	input wire sdmc_mode_t transfer_mode_sel_i,
	input wire logic addr_direction_i,
	input wire logic auto_reload_en_i,
	input wire sdmc_kind_t transfer_kind_i,
	input wire logic wide_i,
	input wire logic enable_i,
	input wire logic dreq_i,
	input wire logic sw_req_i,
	output logic xfer_o,
	output logic xfer_to_mem_o,
	output logic [23:0] addr_o,
	output logic [15:0] count_o,
	output logic tc_o
);
	logic dreq_d_r;
	logic run_r;
	logic armed_r;
	logic ok;
	logic go;
	logic [15:0] step;

	// A channel may move data only when enabled, armed and given a kind.
	always_comb begin
		step = wide_i ? 16'h0002 : 16'h0001;
		ok = enable_i && armed_r && (transfer_kind_i != SDMC_KIND_NONE) &&
			(transfer_kind_i != SDMC_KIND_UNUSED_BITS);
		case (transfer_mode_sel_i)
			SDMC_MODE_DEMAND: go = ok && dreq_i;
			SDMC_MODE_SINGLE: go = ok && dreq_i && !dreq_d_r;
			SDMC_MODE_BLOCK: go = ok && (run_r || (dreq_i && !dreq_d_r) ||
				sw_req_i);
			default: go = 1'b0;
		endcase
	end

	// Address, count and terminal count; loads from software win over a move.
	always_ff @(posedge clk_i) begin
		if (!rst_n_i || clr_i) begin
			dreq_d_r <= 1'b0;
			run_r <= 1'b0;
			armed_r <= 1'b0;
			xfer_o <= 1'b0;
			xfer_to_mem_o <= 1'b0;
			addr_o <= 24'h000000;
			count_o <= 16'h0000;
			tc_o <= 1'b0;
		end else begin
			dreq_d_r <= dreq_i;
			xfer_o <= 1'b0;
			tc_o <= 1'b0;
			if (load_addr_i) begin
				addr_o <= base_addr_i;
			end
			if (load_cnt_i) begin
				count_o <= base_cnt_i;
				armed_r <= 1'b1;
			end
			if (go && !load_addr_i && !load_cnt_i) begin
				xfer_o <= 1'b1;
				xfer_to_mem_o <= (transfer_kind_i == SDMC_KIND_WRITE);
				if (addr_direction_i) begin
					addr_o <= addr_o - {8'h00, step};
				end else begin
					addr_o <= addr_o + {8'h00, step};
				end
				if (count_o <= step) begin
					tc_o <= 1'b1;
					run_r <= 1'b0;
					if (auto_reload_en_i) begin
						addr_o <= base_addr_i;
						count_o <= base_cnt_i;
					end else begin
						count_o <= 16'h0000;
						armed_r <= 1'b0;
					end
				end else begin
					count_o <= count_o - step;
					run_r <= (transfer_mode_sel_i == SDMC_MODE_BLOCK);
				end
			end
		end
	end
endmodule : sdmc_xfer
`default_nettype wire

// *** hdl/sdmc_top.sv ***
// Added by the designer: register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
`include "sdmc_defs.svh"
module sdmc_top
	import sdmc_pkg::*;
#(
	parameter int ADDR_W = 8
) (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic card_dreq_i,
	input wire logic card_present_i,
	output logic xfer_o,
	output logic xfer_to_mem_o,
	output logic [23:0] xfer_addr_o,
	output logic [15:0] xfer_count_o,
	output logic tc_o
);
	// Register indices are cut from address bits 7:2, so eight bits at least.
	if (ADDR_W < 8 || ADDR_W > 32) begin : g_bad_addr_w
		$error("sdmc_top: ADDR_W must lie between 8 and 32.");
	end

	// Write channel state.
	logic aw_have_r;
	logic w_have_r;
	logic [5:0] aw_idx_r;
	logic [31:0] w_data_r;
	logic w_lane0_r;
	logic wr_fire;
	logic wr_hit;

	// Register contents.
	logic [15:0] base_addr_r;
	logic [7:0] page_r;
	logic [15:0] base_cnt_r;
	logic cmd_dis_r;
	logic [7:0] mode_r;
	logic request_block_r;
	logic wide_r;
	logic [3:0] tc_seen_r;
	logic sw_req_r;
	logic master_clr_r;

	// Pin synchronisers and removal detection.
	logic dreq_s1_r;
	logic dreq_s2_r;
	logic card_s1_r;
	logic card_s2_r;
	logic card_d_r;
	logic card_removed;

	// Read path.
	logic [5:0] rd_idx;
	logic [7:0] rd_byte;
	logic rd_ok;
	logic rd_fire;

	// Engine wiring.
	logic eng_xfer;
	logic eng_to_mem;
	logic [23:0] eng_addr;
	logic [15:0] eng_count;
	logic eng_tc;
	logic eng_enable;
	logic load_addr_r;
	logic load_cnt_r;

	// Two flops on each card pin before any logic looks at it.
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			dreq_s1_r <= 1'b0;
			dreq_s2_r <= 1'b0;
			card_s1_r <= 1'b0;
			card_s2_r <= 1'b0;
			card_d_r <= 1'b0;
		end else begin
			dreq_s1_r <= card_dreq_i;
			dreq_s2_r <= dreq_s1_r;
			card_s1_r <= card_present_i;
			card_s2_r <= card_s1_r;
			card_d_r <= card_s2_r;
		end
	end

	assign card_removed = card_d_r && !card_s2_r;

	// Address and data are caught independently, in either order.
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			aw_have_r <= 1'b0;
			w_have_r <= 1'b0;
			aw_idx_r <= 6'h00;
			w_data_r <= 32'h00000000;
			w_lane0_r <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `SDMC_RESP_OKAY;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_have_r <= 1'b1;
				aw_idx_r <= s_axi_awaddr[7:2];
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_have_r <= 1'b1;
				w_data_r <= s_axi_wdata;
				w_lane0_r <= s_axi_wstrb[0];
			end
			if (wr_fire) begin
				aw_have_r <= 1'b0;
				w_have_r <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wr_hit ? `SDMC_RESP_OKAY : `SDMC_RESP_SLVERR;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// Ready is registered so that outputs come straight from flops.
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
		end else begin
			s_axi_awready <= !aw_have_r && !(s_axi_awvalid && s_axi_awready) &&
				!s_axi_bvalid && !wr_fire;
			s_axi_wready <= !w_have_r && !(s_axi_wvalid && s_axi_wready) &&
				!s_axi_bvalid && !wr_fire;
		end
	end

	assign wr_fire = aw_have_r && w_have_r && !s_axi_bvalid;

	// Writes to any of the nine register indices answer OKAY; any other index gets SLVERR.
	always_comb begin
		case (aw_idx_r)
			`SDMC_IDX_ADDR, `SDMC_IDX_PAGE, `SDMC_IDX_COUNT, `SDMC_IDX_CMD,
			`SDMC_IDX_REQ, `SDMC_IDX_MODE, `SDMC_IDX_CLEAR, `SDMC_IDX_MASK,
			`SDMC_IDX_WIDTH: wr_hit = 1'b1;
			default: wr_hit = 1'b0;
		endcase
	end

	// Master clear is a one-cycle pulse; it resets every register below except the read channel flops.
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			master_clr_r <= 1'b0;
		end else begin
			master_clr_r <= wr_fire && (aw_idx_r == `SDMC_IDX_CLEAR);
		end
	end

	// Software-owned configuration; the clear pulse acts like reset.
	always_ff @(posedge clk_i) begin
		if (!rst_n_i || master_clr_r) begin
			base_addr_r <= `SDMC_ADDR_RST;
			page_r <= `SDMC_PAGE_RST;
			base_cnt_r <= `SDMC_COUNT_RST;
			cmd_dis_r <= `SDMC_CMD_DIS_RST;
			mode_r <= {`SDMC_MODE_RST, 2'h0};
			wide_r <= 1'b0;
			sw_req_r <= 1'b0;
		end else begin
			sw_req_r <= wr_fire && (aw_idx_r == `SDMC_IDX_REQ);
			if (wr_fire && w_lane0_r) begin
				case (aw_idx_r)
					`SDMC_IDX_ADDR: base_addr_r <= w_data_r[15:0];
					`SDMC_IDX_PAGE: page_r <= w_data_r[7:0];
					`SDMC_IDX_COUNT: base_cnt_r <= w_data_r[15:0];
					`SDMC_IDX_CMD: cmd_dis_r <= w_data_r[`SDMC_CMD_DIS_BIT];
					// Low two bits are never stored, so they read as zero.
					`SDMC_IDX_MODE: mode_r <= {w_data_r[7:2], 2'h0};
					`SDMC_IDX_WIDTH: wide_r <= w_data_r[`SDMC_WIDTH_BIT];
					default: ;
				endcase
			end
		end
	end

	// The mask bit starts set; card removal sets it and beats a write.
	always_ff @(posedge clk_i) begin
		if (!rst_n_i || master_clr_r) begin
			request_block_r <= `SDMC_MASK_RST;
		end else if (card_removed) begin
			request_block_r <= 1'b1;
		end else if (wr_fire && w_lane0_r && aw_idx_r == `SDMC_IDX_MASK) begin
			request_block_r <= w_data_r[`SDMC_MASK_BIT];
		end
	end

	// Terminal count bits stick until status is read; a new count wins.
	always_ff @(posedge clk_i) begin
		if (!rst_n_i || master_clr_r) begin
			tc_seen_r <= 4'h0;
		end else if (eng_tc) begin
			tc_seen_r <= 4'hf;
		end else if (rd_fire && rd_idx == `SDMC_IDX_CMD) begin
			tc_seen_r <= 4'h0;
		end
	end

	assign rd_idx = s_axi_araddr[7:2];
	assign rd_fire = s_axi_arvalid && s_axi_arready;

	// Read mux; index 08h reads status while writes there reach the command.
	always_comb begin
		rd_ok = 1'b1;
		case (rd_idx)
			`SDMC_IDX_ADDR: rd_byte = eng_addr[7:0];
			`SDMC_IDX_PAGE: rd_byte = eng_addr[23:16];
			`SDMC_IDX_COUNT: rd_byte = eng_count[7:0];
			`SDMC_IDX_CMD: rd_byte = {{4{dreq_s2_r}}, tc_seen_r};
			`SDMC_IDX_MODE: rd_byte = {mode_r[7:2], 2'h0};
			`SDMC_IDX_MASK: rd_byte = {7'h00, request_block_r};
			`SDMC_IDX_WIDTH: rd_byte = {7'h00, wide_r};
			default: begin
				rd_byte = 8'h00;
				rd_ok = 1'b0;
			end
		endcase
	end

	// Read answers one cycle after the address is taken.
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= `SDMC_RESP_OKAY;
		end else begin
			s_axi_arready <= !s_axi_rvalid && !rd_fire;
			if (rd_fire) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp <= rd_ok ? `SDMC_RESP_OKAY : `SDMC_RESP_SLVERR;
				if (rd_idx == `SDMC_IDX_COUNT) begin
					s_axi_rdata <= {16'h0000, eng_count};
				end else if (rd_idx == `SDMC_IDX_ADDR) begin
					s_axi_rdata <= {16'h0000, eng_addr[15:0]};
				end else begin
					s_axi_rdata <= {24'h000000, rd_byte};
				end
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	// Card requests pass only while unmasked and the controller is on.
	assign eng_enable = !request_block_r && !cmd_dis_r;

	// Loads trail the register write by one cycle, so the engine copies the
	// value just stored rather than the one it replaces.
	always_ff @(posedge clk_i) begin
		if (!rst_n_i || master_clr_r) begin
			load_addr_r <= 1'b0;
			load_cnt_r <= 1'b0;
		end else begin
			load_addr_r <= wr_fire && w_lane0_r &&
				(aw_idx_r == `SDMC_IDX_ADDR || aw_idx_r == `SDMC_IDX_PAGE);
			load_cnt_r <= wr_fire && w_lane0_r &&
				(aw_idx_r == `SDMC_IDX_COUNT);
		end
	end

	sdmc_xfer u_xfer (
		.clk_i(clk_i),
		.rst_n_i(rst_n_i),
		.clr_i(master_clr_r),
		.load_addr_i(load_addr_r),
		.load_cnt_i(load_cnt_r),
		.base_addr_i({page_r, base_addr_r}),
		.base_cnt_i(base_cnt_r),
		// Mode fields decoded straight from their bit positions.
		.transfer_mode_sel_i(sdmc_mode_t'(mode_r[7:6])),
		.addr_direction_i(mode_r[`SDMC_MODE_DIR_BIT]),
		.auto_reload_en_i(mode_r[`SDMC_MODE_AUTO_BIT]),
		.transfer_kind_i(sdmc_kind_t'(mode_r[3:2])),
		.wide_i(wide_r),
		.enable_i(eng_enable),
		.dreq_i(dreq_s2_r),
		.sw_req_i(sw_req_r),
		.xfer_o(eng_xfer),
		.xfer_to_mem_o(eng_to_mem),
		.addr_o(eng_addr),
		.count_o(eng_count),
		.tc_o(eng_tc)
	);

	// Engine outputs are flops already; these wires only rename them.
	assign xfer_o = eng_xfer;
	assign xfer_to_mem_o = eng_to_mem;
	assign xfer_addr_o = eng_addr;
	assign xfer_count_o = eng_count;
	assign tc_o = eng_tc;
endmodule : sdmc_top
`default_nettype wire

// *** tb/sdmc_card_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module sdmc_card_model (
	input wire logic clk_i,
	output logic dreq_o,
	output logic present_o
);
	// The card starts seated and quiet.
	initial begin
		dreq_o = 1'b0;
		present_o = 1'b1;
	end
	// Holds the request for n cycles; the socket is free to ignore it.
	task automatic req(input int n);
		@(posedge clk_i);
		dreq_o <= 1'b1;
		repeat (n) @(posedge clk_i);
		dreq_o <= 1'b0;
	endtask : req
	// A pulled card cannot keep asking, so the request drops with it.
	task automatic seat(input logic v);
		@(posedge clk_i);
		present_o <= v;
		dreq_o <= 1'b0;
	endtask : seat
endmodule : sdmc_card_model
`default_nettype wire

// *** tb/sdmc_chk.sv ***
`timescale 1ns/1ps
`default_nettype none
module sdmc_chk
	import sdmc_pkg::*;
#(
	parameter int ADDR_W = 8
) (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic s_axi_rvalid,
	input wire logic card_present_i,
	input wire logic xfer_o,
	input wire logic xfer_to_mem_o,
	input wire logic [23:0] xfer_addr_o,
	input wire logic [15:0] xfer_count_o,
	input wire logic tc_o
);
	logic [5:0] wix_r, rix_r;
	logic [7:0] wd_r, mode_r;
	logic ws_r, bv_r, bnew;
	assign bnew = s_axi_bvalid && !bv_r;
	// Remember which places the bus is talking to.
	always_ff @(posedge clk_i) begin
		if (s_axi_awvalid && s_axi_awready) wix_r <= s_axi_awaddr[7:2];
		if (s_axi_wvalid && s_axi_wready) wd_r <= s_axi_wdata[7:0];
		if (s_axi_wvalid && s_axi_wready) ws_r <= s_axi_wstrb[0];
		if (s_axi_arvalid && s_axi_arready) rix_r <= s_axi_araddr[7:2];
	end
	// Mode shadow, committed late on purpose: transfers start later still.
	always_ff @(posedge clk_i) begin
		bv_r <= s_axi_bvalid;
		if (!rst_n_i || (bnew && wix_r == 6'h0d)) mode_r <= 8'h00;
		else if (bnew && wix_r == 6'h0b && ws_r) mode_r <= wd_r;
	end
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);
	a_mode_low_zero: assert property (
		s_axi_rvalid && rix_r == 6'h0b |->
		s_axi_rdata[1:0] == 2'h0 && s_axi_rdata[31:8] == 24'h0)
		else $error("mode read shows reserved bits");
	a_mask_high_zero: assert property (
		s_axi_rvalid && rix_r == 6'h0f |-> s_axi_rdata[31:1] == 31'h0)
		else $error("mask read shows upper bits");
	a_clear_resets: assert property (
		bnew && wix_r == 6'h0d |->
		##2 xfer_count_o == 16'h0 && xfer_addr_o == 24'h0)
		else $error("master clear left state behind");
	a_kind_direction: assert property (
		xfer_o |-> xfer_to_mem_o == (mode_r[3:2] == SDMC_KIND_WRITE))
		else $error("transfer direction wrong");
	a_addr_step_dir: assert property (
		xfer_o && !tc_o |-> (mode_r[5] ?
		xfer_addr_o < $past(xfer_addr_o) : xfer_addr_o > $past(xfer_addr_o)))
		else $error("address moved the wrong way");
	a_count_step: assert property (
		xfer_o && !tc_o |->
		16'($past(xfer_count_o) - xfer_count_o) inside {16'h1, 16'h2})
		else $error("count step wrong");
	a_tc_empties: assert property (
		tc_o && !mode_r[4] |-> xfer_o && xfer_count_o == 16'h0)
		else $error("terminal count left a count");
	a_reload_base: assert property (
		tc_o && mode_r[4] |-> xfer_count_o != 16'h0)
		else $error("no reload at terminal count");
	a_removal_masks: assert property (
		$fell(card_present_i) |-> ##5 (!xfer_o) [*6])
		else $error("transfer after card removal");
	a_reset_masked: assert property (
		$rose(rst_n_i) |-> (!xfer_o) [*8])
		else $error("transfer straight after reset");
endmodule : sdmc_chk
bind sdmc_top sdmc_chk #(.ADDR_W(ADDR_W)) u_chk (.clk_i, .rst_n_i,
	.s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
	.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
	.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
	.s_axi_rvalid, .card_present_i, .xfer_o, .xfer_to_mem_o,
	.xfer_addr_o, .xfer_count_o, .tc_o);
`default_nettype wire

// *** tb/tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic clk_i = 1'b0, rst_n_i = 1'b0;
	logic awv = 1'b0, wv = 1'b0, brd = 1'b0, arv = 1'b0, rrd = 1'b0;
	logic [7:0] awa = 8'h00, ara = 8'h00;
	logic [31:0] wd = 32'h0;
	wire logic awr, wrd, bv, arr, rv, dreq, pres, xf, tom, tc;
	wire logic [1:0] br, rr;
	wire logic [31:0] rdat;
	wire logic [23:0] xa;
	wire logic [15:0] xc;
	int n_fail = 0, checks = 0, nx = 0, nm = 0, nt = 0;
	sdmc_top dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .s_axi_awaddr(awa),
		.s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
		.s_axi_wstrb(4'hf), .s_axi_wvalid(wv), .s_axi_wready(wrd),
		.s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(brd),
		.s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
		.s_axi_rdata(rdat), .s_axi_rresp(rr), .s_axi_rvalid(rv),
		.s_axi_rready(rrd), .card_dreq_i(dreq), .card_present_i(pres),
		.xfer_o(xf), .xfer_to_mem_o(tom), .xfer_addr_o(xa),
		.xfer_count_o(xc), .tc_o(tc));
	sdmc_card_model card (.clk_i(clk_i), .dreq_o(dreq), .present_o(pres));
	// 25 MHz clock.
	initial forever #20 clk_i = ~clk_i;
	// Pulses are tallied here so each scenario can take a difference.
	always @(posedge clk_i) begin
		if (xf === 1'b1) nx <= nx + 1;
		if (xf === 1'b1 && tom === 1'b1) nm <= nm + 1;
		if (tc === 1'b1) nt <= nt + 1;
	end
	task automatic print_verdict;
		if (n_fail == 0 && checks > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask : print_verdict
	task automatic cmp(input string nm, input logic [31:0] e, g);
		checks++;
		if (g !== e) begin
			n_fail++;
			$display("mismatch %s exp %h got %h", nm, e, g);
		end
	endtask : cmp
	// A wait that used up its bound ends the run as a failure.
	task automatic hang(input int k);
		if (k >= 60) begin
			n_fail++;
			print_verdict();
		end
	endtask : hang
	task automatic wr(input logic [5:0] ix, input logic [7:0] d,
		input logic [1:0] er = 2'h0);
		int k;
		k = 0;
		@(posedge clk_i);
		awa <= {ix, 2'h0};
		wd <= {24'h0, d};
		awv <= 1'b1;
		wv <= 1'b1;
		brd <= 1'b1;
		do begin
			@(posedge clk_i);
			k++;
			if (awr === 1'b1) awv <= 1'b0;
			if (wrd === 1'b1) wv <= 1'b0;
		end while (bv !== 1'b1 && k < 60);
		brd <= 1'b0;
		hang(k);
		cmp("bresp", er, br);
	endtask : wr
	task automatic rd(input logic [5:0] ix, input logic [7:0] e,
		input logic [1:0] er = 2'h0);
		int k;
		k = 0;
		@(posedge clk_i);
		ara <= {ix, 2'h0};
		arv <= 1'b1;
		rrd <= 1'b1;
		do begin
			@(posedge clk_i);
			k++;
			if (arr === 1'b1) arv <= 1'b0;
		end while (rv !== 1'b1 && k < 60);
		rrd <= 1'b0;
		hang(k);
		cmp("rresp", er, rr);
		cmp("rdata", e, rdat);
	endtask : rd
	// Arms a run; len 0 asks by software, a negative e gives a count that the run must exceed.
	task automatic run(input logic [7:0] m, c, input int len, e);
		int n0;
		wr(6'h0b, m);
		wr(6'h04, c);
		n0 = nx;
		if (len == 0) wr(6'h09, 8'h01);
		else card.req(len);
		repeat (10) @(posedge clk_i);
		if (e >= 0) cmp("xfers", e, nx - n0);
		else cmp("xfer_min", 1, nx - n0 > -e);
	endtask : run
	initial begin
		repeat (8) @(posedge clk_i);
		rst_n_i <= 1'b1;
		rd(6'h0b, 8'h00);
		rd(6'h0f, 8'h01);
		rd(6'h0d, 8'h00, 2'h2);
		wr(6'h3f, 8'h5a, 2'h2);
		rd(6'h3f, 8'h00, 2'h2);
		wr(6'h0b, 8'hff);
		rd(6'h0b, 8'hfc);
		wr(6'h0f, 8'hff);
		rd(6'h0f, 8'h01);
		wr(6'h0f, 8'h00);
		wr(6'h10, 8'h00);
		wr(6'h00, 8'h10);
		run(8'h04, 8'h03, 10, 3);
		cmp("addr", 24'h13, xa);
		cmp("count", 16'h0, xc);
		cmp("to_mem", 3, nm);
		cmp("tc_pulses", 1, nt);
		wr(6'h10, 8'h01);
		wr(6'h00, 8'h20);
		run(8'h28, 8'h04, 10, 2);
		cmp("addr", 24'h1c, xa);
		cmp("to_mem", 3, nm);
		cmp("tc_pulses", 2, nt);
		wr(6'h10, 8'h00);
		run(8'h44, 8'h05, 10, 1);
		run(8'h84, 8'h03, 1, 3);
		run(8'h84, 8'h03, 0, 3);
		run(8'h04, 8'h03, 0, 0);
		run(8'h0c, 8'h03, 10, 0);
		run(8'hc4, 8'h03, 10, 0);
		run(8'h00, 8'h03, 10, 0);
		run(8'h14, 8'h02, 20, -2);
		wr(6'h0f, 8'h01);
		run(8'h04, 8'h03, 10, 0);
		wr(6'h0f, 8'h00);
		card.seat(1'b0);
		repeat (6) @(posedge clk_i);
		rd(6'h0f, 8'h01);
		card.seat(1'b1);
		run(8'h04, 8'h03, 10, 0);
		wr(6'h0f, 8'h00);
		run(8'h04, 8'h03, 10, 3);
		wr(6'h0b, 8'h54);
		wr(6'h0d, 8'h00);
		rd(6'h0b, 8'h00);
		rd(6'h0f, 8'h01);
		cmp("addr", 24'h0, xa);
		print_verdict();
	end
endmodule : tb
`default_nettype wire
